/* common/epc_pkg.sv */
package epc_pkg;

  // Command codes
  localparam logic [7:0] CMD_MASTER_ACT  = 8'h20;
  localparam logic [7:0] CMD_UPD_SEQ     = 8'h22;
  localparam logic [7:0] CMD_WR_MONO     = 8'h24;
  localparam logic [7:0] CMD_WR_YELLOW   = 8'h26;
  localparam logic [7:0] CMD_WR_VCE      = 8'h2c;
  localparam logic [7:0] CMD_RD_OPTION   = 8'h2d;

  // Register offset and reset values
  localparam logic [7:0] OFS_COMMON_ELECTRODE_VOLTAGE = 8'h2c;
  localparam logic [7:0] RST_COMMON_ELECTRODE_VOLTAGE = 8'h00;
  localparam logic [7:0] RST_UPD_SEQ                  = 8'hff;

  // Update sequence option with one stage before the clock-off stage
  localparam logic [7:0] SEQ_CLOCK_OFF_ONLY = 8'h03;

  // Option record layout
  localparam int OPT_BYTES       = 11;
  localparam int OPT_MODE_FIRST  = 2;
  localparam int OPT_MODE_COUNT  = 5;
  localparam int OPT_WAVE_FIRST  = 7;
  localparam int OPT_WAVE_COUNT  = 4;

  // Update sequence stage time, per enabled stage
  localparam int STAGE_TIME_NS   = 1000;
  localparam int CLK_PERIOD_NS   = 50;
  localparam int STAGE_CYCLES    = (STAGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Decoder state
  typedef enum logic [2:0] {
    EPC_IDLE   = 3'b000,
    EPC_MONO   = 3'b001,
    EPC_YELLOW = 3'b011,
    EPC_VCE    = 3'b010,
    EPC_SEQ    = 3'b110,
    EPC_READ   = 3'b111
  } epc_state_e;

endpackage

/* src/epc_frame_mem.sv */
`timescale 1ns/1ps
module epc_frame_mem #(
  parameter int AW = 12
) (
  // Clock
  input  wire logic          clk_sys_in,
  input  wire logic          ce_in,
  // Write port
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [7:0]    wr_data_in,
  // Read port
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [7:0]    rd_data_out
);

  // Storage array
  logic [7:0] mem_reg [0:(1<<AW)-1];

  // Write and registered read
  always_ff @(posedge clk_sys_in) begin
    if (ce_in) begin
      if (wr_en_in) begin
        mem_reg[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem_reg[rd_addr_in];
    end
  end

endmodule

/* src/epc_cmd_decoder.sv */
`timescale 1ns/1ps
// Contract
// - 24h streams data into mono memory
// - 26h streams data into yellow memory
// - 2Ch loads voltage register, reset zero
// - 2Dh reads OTP selection, then voltage
// - Bytes three-seven: five display mode bytes
// - Bytes eight-eleven: four waveform version bytes
// - Option 03h runs two stages, clock-off last
// - Activation runs stored stages, uninterruptible
module epc_cmd_decoder #(
  parameter int AW = 12,
  parameter logic [7:0] OTP_VCOM_SEL = 8'h00,
  parameter logic [39:0] OTP_MODE    = 40'h0000000000,
  parameter logic [31:0] OTP_WAVE    = 32'h00000000
) (
  // Clock and reset
  input  wire logic          clk_sys_in,
  input  wire logic          nrst_in,
  input  wire logic          ce_in,
  // Host byte stream
  input  wire logic          byte_valid_in,
  input  wire logic          byte_is_data_in,
  input  wire logic [7:0]    byte_in,
  input  wire logic          read_req_in,
  // Host read side
  output logic      [7:0]    rd_byte_out,
  output logic               rd_valid_out,
  // Frame memory readout for the panel
  input  wire logic [AW-1:0] scan_addr_in,
  output logic      [7:0]    mono_scan_out,
  output logic      [7:0]    yellow_scan_out,
  // Status
  output logic      [7:0]    vce_out,
  output logic      [7:0]    upd_seq_out,
  output logic               busy_out,
  output logic               clk_on_out
);

  epc_pkg::epc_state_e state_reg;
  logic [AW-1:0] addr_reg;         // Shared address pointer
  logic [3:0]    rd_idx_reg;       // Option record index
  logic [7:0]    vce_reg;          // Common electrode voltage
  logic [7:0]    seq_reg;          // Update sequence option
  logic [7:0]    stages_reg;       // Remaining stages mask
  logic [15:0]   stage_cnt_reg;    // Stage timer
  logic          clk_on_reg;       // Internal clock state
  logic          is_cmd;
  logic          is_data;
  logic          mono_we;
  logic          yellow_we;

  // Byte kind split by select line
  // command or data
  assign is_cmd    = ce_in && byte_valid_in && !byte_is_data_in && !busy_out;
  assign is_data   = ce_in && byte_valid_in && byte_is_data_in && !busy_out;
  assign mono_we   = is_data && (state_reg == epc_pkg::EPC_MONO);
  assign yellow_we = is_data && (state_reg == epc_pkg::EPC_YELLOW);

  // Option record byte picker
  function automatic logic [7:0] opt_byte(input logic [3:0] idx, input logic [7:0] vce);
    if (idx == 4'h0) begin
      opt_byte = OTP_VCOM_SEL;
    end else if (idx == 4'h1) begin
      opt_byte = vce;
    end else if (idx < 4'(epc_pkg::OPT_WAVE_FIRST)) begin
      opt_byte = OTP_MODE[8*(4 - (32'(idx) - epc_pkg::OPT_MODE_FIRST)) +: 8];
    end else if (idx < 4'(epc_pkg::OPT_BYTES)) begin
      opt_byte = OTP_WAVE[8*(3 - (32'(idx) - epc_pkg::OPT_WAVE_FIRST)) +: 8];
    end else begin
      opt_byte = 8'h00;
    end
  endfunction

  // Highest stage still pending in a stage mask, one-hot
  function automatic logic [7:0] top_stage(input logic [7:0] mask);
    top_stage = 8'h00;
    for (int b = 0; b < 8; b++) begin
      // Later hits are higher bits and win
      if (mask[b]) begin
        top_stage = 8'h01 << b;
      end
    end
  endfunction

  // Decoder state machine
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= epc_pkg::EPC_IDLE;
    end else if (is_cmd) begin
      case (byte_in)
        epc_pkg::CMD_WR_MONO:   state_reg <= epc_pkg::EPC_MONO;
        epc_pkg::CMD_WR_YELLOW: state_reg <= epc_pkg::EPC_YELLOW;
        epc_pkg::CMD_WR_VCE:    state_reg <= epc_pkg::EPC_VCE;
        epc_pkg::CMD_UPD_SEQ:   state_reg <= epc_pkg::EPC_SEQ;
        epc_pkg::CMD_RD_OPTION: state_reg <= epc_pkg::EPC_READ;
        default:                state_reg <= epc_pkg::EPC_IDLE;
      endcase
    end else if (is_data && (state_reg == epc_pkg::EPC_VCE || state_reg == epc_pkg::EPC_SEQ)) begin
      state_reg <= epc_pkg::EPC_IDLE;
    end
  end

  // Address pointer
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr_reg <= '0;
    end else if (is_cmd) begin
      addr_reg <= '0;
    end else if (mono_we || yellow_we) begin
      addr_reg <= addr_reg + 1'b1;
    end
  end

  // Voltage and sequence option registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vce_reg <= epc_pkg::RST_COMMON_ELECTRODE_VOLTAGE;
      seq_reg <= epc_pkg::RST_UPD_SEQ;
    end else if (is_data && state_reg == epc_pkg::EPC_VCE) begin
      vce_reg <= byte_in;
    end else if (is_data && state_reg == epc_pkg::EPC_SEQ) begin
      seq_reg <= byte_in;
    end
  end

  // Option readback, one byte per host read
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_idx_reg   <= 4'h0;
      rd_byte_out  <= 8'h00;
      rd_valid_out <= 1'b0;
    end else if (ce_in) begin
      rd_valid_out <= 1'b0;
      if (is_cmd) begin
        rd_idx_reg <= 4'h0;
      end else if (read_req_in && state_reg == epc_pkg::EPC_READ) begin
        rd_byte_out  <= opt_byte(rd_idx_reg, vce_reg);
        rd_valid_out <= 1'b1;
        if (rd_idx_reg < 4'(epc_pkg::OPT_BYTES)) begin
          rd_idx_reg <= rd_idx_reg + 4'h1;
        end
      end
    end
  end

  // Update sequencer: one timed slot per enabled stage bit
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stages_reg    <= 8'h00;
      stage_cnt_reg <= 16'h0000;
      busy_out      <= 1'b0;
      clk_on_reg    <= 1'b0;
    end else if (ce_in) begin
      if (!busy_out && is_cmd && byte_in == epc_pkg::CMD_MASTER_ACT) begin
        stages_reg    <= seq_reg;
        stage_cnt_reg <= 16'(epc_pkg::STAGE_CYCLES);
        busy_out      <= (seq_reg != 8'h00);
      end else if (busy_out) begin
        if (stage_cnt_reg != 16'h0000) begin
          stage_cnt_reg <= stage_cnt_reg - 16'h0001;
        end else begin
          // Slot just ended belongs to the highest pending stage
          if (top_stage(stages_reg) == 8'h80) begin
            clk_on_reg <= 1'b1;
          end
          if (top_stage(stages_reg) == 8'h01) begin
            clk_on_reg <= 1'b0;
          end
          // Retire that stage, stop when none is left
          stages_reg    <= stages_reg & ~top_stage(stages_reg);
          stage_cnt_reg <= 16'(epc_pkg::STAGE_CYCLES);
          busy_out      <= ((stages_reg & ~top_stage(stages_reg)) != 8'h00);
        end
      end
    end
  end

  // Registered status outputs
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vce_out     <= epc_pkg::RST_COMMON_ELECTRODE_VOLTAGE;
      upd_seq_out <= epc_pkg::RST_UPD_SEQ;
      clk_on_out  <= 1'b0;
    end else if (ce_in) begin
      vce_out     <= vce_reg;
      upd_seq_out <= seq_reg;
      clk_on_out  <= clk_on_reg;
    end
  end

  // Mono frame memory
  epc_frame_mem #(.AW(AW)) u_mono_frame_memory (
    .clk_sys_in  (clk_sys_in),
    .ce_in       (ce_in),
    .wr_en_in    (mono_we),
    .wr_addr_in  (addr_reg),
    .wr_data_in  (byte_in),
    .rd_addr_in  (scan_addr_in),
    .rd_data_out (mono_scan_out)
  );

  // Yellow frame memory
  epc_frame_mem #(.AW(AW)) u_yellow_frame_memory (
    .clk_sys_in  (clk_sys_in),
    .ce_in       (ce_in),
    .wr_en_in    (yellow_we),
    .wr_addr_in  (addr_reg),
    .wr_data_in  (byte_in),
    .rd_addr_in  (scan_addr_in),
    .rd_data_out (yellow_scan_out)
  );

endmodule

/* dv/epc_chk_asserts.sv */
`timescale 1ns/1ps
module epc_chk #(
  parameter logic [7:0]  OTP_VCOM_SEL = 8'h00,
  parameter logic [39:0] OTP_MODE     = 40'h0,
  parameter logic [31:0] OTP_WAVE     = 32'h0
) (
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       nrst_in,
  // Host side
  input wire logic       ce_in,
  input wire logic       byte_valid_in,
  input wire logic       byte_is_data_in,
  input wire logic [7:0] byte_in,
  input wire logic       read_req_in,
  // Device side
  input wire logic [7:0] rd_byte_out,
  input wire logic       rd_valid_out,
  input wire logic [7:0] vce_out,
  input wire logic [7:0] upd_seq_out,
  input wire logic       busy_out,
  input wire logic       clk_on_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  logic        vce_arm;  // Voltage byte expected
  logic        rd_arm;   // Readback state
  logic [3:0]  rd_idx;   // Next record index
  logic [3:0]  rd_last;  // Index being answered
  logic [7:0]  exp_b;    // Expected answer
  wire logic        take = ce_in & byte_valid_in & !busy_out;
  wire logic        cmd  = take & !byte_is_data_in;
  wire logic        rtk  = ce_in & read_req_in & rd_arm;
  wire logic [87:0] rec  = {OTP_VCOM_SEL, vce_out, OTP_MODE, OTP_WAVE};
  // Command state and expected record byte
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vce_arm <= 1'b0;
      rd_arm  <= 1'b0;
      rd_idx  <= 4'h0;
      rd_last <= 4'h0;
      exp_b   <= 8'h00;
    end else begin
      if (take) vce_arm <= cmd && byte_in == epc_pkg::CMD_WR_VCE;
      if (cmd) rd_arm <= byte_in == epc_pkg::CMD_RD_OPTION;
      if (cmd) rd_idx <= 4'h0;
      else if (rtk && rd_idx != 4'hf) rd_idx <= rd_idx + 4'h1;
      if (rtk) rd_last <= rd_idx;
      if (rtk) exp_b <= (rd_idx < 4'hb) ? rec[8*(10-int'(rd_idx)) +: 8] : 8'h00;
    end
  end
  AST_VCE_LOAD: assert property (
    take && byte_is_data_in && vce_arm |-> ##2 vce_out == $past(byte_in, 2)) else $error("vce load");
  AST_VCE_HOLD: assert property (
    $changed(vce_out) |-> $past(take && byte_is_data_in && vce_arm, 2)) else $error("vce moved");
  AST_RD_ONLY: assert property (
    rd_valid_out |-> $past(rtk)) else $error("unrequested read byte");
  AST_RD_HEAD: assert property (
    rd_valid_out && rd_last < 4'h2 |-> rd_byte_out == exp_b) else $error("read head");
  AST_RD_MODE: assert property (
    rd_valid_out && rd_last inside {[2:6]} |-> rd_byte_out == exp_b) else $error("read mode");
  AST_RD_WAVE: assert property (
    rd_valid_out && rd_last inside {[7:10]} |-> rd_byte_out == exp_b) else $error("read wave");
  AST_BUSY_START: assert property (
    cmd && byte_in == 8'h20 && upd_seq_out != 8'h00 |=> busy_out) else $error("no busy");
  AST_SEQ03: assert property (
    cmd && byte_in == 8'h20 && upd_seq_out == 8'h03 |-> ##1 busy_out ##41 busy_out
    ##1 !busy_out ##1 !clk_on_out) else $error("seq 03 length");
  AST_SEQ80: assert property (
    cmd && byte_in == 8'h20 && upd_seq_out == 8'h80 |-> ##1 busy_out ##20 busy_out
    ##1 !busy_out ##1 clk_on_out) else $error("seq 80 length");
  cover property (rtk ##1 rd_valid_out);
  cover property ($rose(clk_on_out));
  cover property ($fell(busy_out));
  cover property (take && byte_is_data_in && vce_arm);
endmodule
bind epc_cmd_decoder epc_chk #(.OTP_VCOM_SEL(OTP_VCOM_SEL), .OTP_MODE(OTP_MODE),
  .OTP_WAVE(OTP_WAVE)) epc_chk_inst (.clk_sys_in, .nrst_in, .ce_in, .byte_valid_in,
  .byte_is_data_in, .byte_in, .read_req_in, .rd_byte_out, .rd_valid_out, .vce_out,
  .upd_seq_out, .busy_out, .clk_on_out);

/* dv/epc_host_model.sv */
`timescale 1ns/1ps
module epc_host_model (
  // Clock and readback
  input  wire logic       clk_sys_in,
  input  wire logic       rd_valid_in,
  input  wire logic [7:0] rd_byte_in,
  // Byte stream
  output logic            byte_valid_out,
  output logic            byte_is_data_out,
  output logic [7:0]      byte_out,
  output logic            read_req_out
);
  initial begin
    byte_valid_out = 1'b0;
    byte_is_data_out = 1'b0;
    byte_out = 8'h00;
    read_req_out = 1'b0;
  end
  task automatic put(input logic d, input logic [7:0] b);
    @(posedge clk_sys_in);
    byte_valid_out <= 1'b1;
    byte_is_data_out <= d;
    byte_out <= b;
    @(posedge clk_sys_in);
    byte_valid_out <= 1'b0;
    byte_out <= ~b;  // Released bus never shows stale byte
  endtask
  // One read cycle, answer sampled once settled
  task automatic get(output logic [7:0] b, output logic seen);
    b = 8'hxx;
    seen = 1'b0;
    @(posedge clk_sys_in);
    read_req_out <= 1'b1;
    @(posedge clk_sys_in);
    read_req_out <= 1'b0;
    repeat (3) begin
      #1;
      if (rd_valid_in === 1'b1) begin
        b = rd_byte_in;
        seen = 1'b1;
        break;
      end
      @(posedge clk_sys_in);
    end
  endtask
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
  localparam logic [87:0] REC = {8'h5e, 8'h3c, 40'h0102030405, 32'ha1b2c3d4};
  logic clk_sys_in, nrst_in, bv, bd, rq, rv, busy, clk_on, ce, seen;
  logic [7:0] bb, rb, vce, seq, mono, yel, got;
  logic [11:0] scan;
  logic [7:0] mexp [3] = '{8'h2c, 8'h5a, 8'hc3};
  int err_total, n_checks, i;
  epc_host_model epc_host_model_inst (.clk_sys_in, .rd_valid_in(rv), .rd_byte_in(rb),
    .byte_valid_out(bv), .byte_is_data_out(bd), .byte_out(bb), .read_req_out(rq));
  epc_cmd_decoder #(.OTP_VCOM_SEL(REC[87:80]), .OTP_MODE(REC[71:32]), .OTP_WAVE(REC[31:0]))
    epc_cmd_decoder_inst (.clk_sys_in, .nrst_in, .ce_in(ce), .byte_valid_in(bv),
    .byte_is_data_in(bd), .byte_in(bb), .read_req_in(rq), .rd_byte_out(rb), .rd_valid_out(rv),
    .scan_addr_in(scan), .mono_scan_out(mono), .yellow_scan_out(yel), .vce_out(vce),
    .upd_seq_out(seq), .busy_out(busy), .clk_on_out(clk_on));
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Bounded wait for busy to fall, n counts edges from the activation edge
  task automatic wait_idle(input int start, output int n);
    n = start;
    #1;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    if (n >= 100) err_total++;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    nrst_in = 1'b0;
    ce = 1'b1;
    scan = 12'h000;
    repeat (10) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    check(vce, 8'h00);
    // Mono stream holds a command-like data byte, yellow resets pointer
    epc_host_model_inst.put(1'b0, epc_pkg::CMD_WR_MONO);
    for (i = 0; i < 3; i++) epc_host_model_inst.put(1'b1, mexp[i]);
    epc_host_model_inst.put(1'b0, epc_pkg::CMD_WR_YELLOW);
    for (i = 0; i < 2; i++) epc_host_model_inst.put(1'b1, ~mexp[i]);
    for (i = 0; i < 3; i++) begin
      @(posedge clk_sys_in);
      scan <= i[11:0];
      @(posedge clk_sys_in);
      #1 check(mono, mexp[i]);
      if (i < 2) check(yel, ~mexp[i]);
    end
    $display("test frame memory done");
    epc_host_model_inst.put(1'b0, epc_pkg::CMD_WR_VCE);
    epc_host_model_inst.put(1'b1, 8'h3c);
    repeat (2) @(posedge clk_sys_in);
    #1 check(vce, 8'h3c);
    // Bytes offered while the clock enable is low are not taken
    @(posedge clk_sys_in);
    ce <= 1'b0;
    epc_host_model_inst.put(1'b0, epc_pkg::CMD_WR_VCE);
    epc_host_model_inst.put(1'b1, 8'h77);
    ce <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1 check(vce, 8'h3c);
    // Read cycle outside the readback command gets no answer
    epc_host_model_inst.get(got, seen);
    check({7'h00, seen}, 8'h00);
    epc_host_model_inst.put(1'b0, epc_pkg::CMD_RD_OPTION);
    for (i = 0; i < 12; i++) begin
      epc_host_model_inst.get(got, seen);
      check({7'h00, seen}, 8'h01);
      check(got, (i < epc_pkg::OPT_BYTES) ? REC[8*(10-i) +: 8] : 8'h00);
    end
    $display("test readback done");
    // Clock-on stage alone: one slot, clock left running
    epc_host_model_inst.put(1'b0, epc_pkg::CMD_UPD_SEQ);
    epc_host_model_inst.put(1'b1, 8'h80);
    epc_host_model_inst.put(1'b0, epc_pkg::CMD_MASTER_ACT);
    wait_idle(0, i);
    check(i[7:0], 8'(epc_pkg::STAGE_CYCLES + 1));
    @(posedge clk_sys_in);
    #1 check({7'h00, clk_on}, 8'h01);
    // Clock-off option, with bytes sent while busy
    epc_host_model_inst.put(1'b0, epc_pkg::CMD_UPD_SEQ);
    epc_host_model_inst.put(1'b1, epc_pkg::SEQ_CLOCK_OFF_ONLY);
    epc_host_model_inst.put(1'b0, epc_pkg::CMD_MASTER_ACT);
    epc_host_model_inst.put(1'b0, epc_pkg::CMD_WR_VCE);
    epc_host_model_inst.put(1'b1, 8'h99);
    wait_idle(4, i);
    check(i[7:0], 8'(2 * (epc_pkg::STAGE_CYCLES + 1)));
    check(vce, 8'h3c);
    @(posedge clk_sys_in);
    #1 check({7'h00, clk_on}, 8'h00);
    $display("test update sequence done");
    report_and_stop();
  end
endmodule
